// [rtl/cmt_pkg.sv]
// package: mode code layout, ratio encodings and tick constants for the clock-mode tick generator
package cmt_pkg;
  // ---------------------------------------------------------------
  // mode word layout
  // ---------------------------------------------------------------
  localparam int MODE_W = 7;
  localparam int UPPER_LSB = 3;
  localparam int CFG_WORD_UPPER_LSB = 28;
  localparam int CFG_WORD_UPPER_MSB = 31;
  // ---------------------------------------------------------------
  // ratios held as twice the factor (so 2.5 becomes 5)
  // ---------------------------------------------------------------
  localparam int RATIO_W = 5;
  localparam logic [4:0] RATIO_HALF_2_5 = 5'h05;
  localparam logic [4:0] RATIO_HALF_3_5 = 5'h07;
  // ---------------------------------------------------------------
  // tick positions in quarters/tenths/fourteenths of the period, held as sub-steps
  // the divider counts STEPS_QUARTER, STEPS_TENTH or STEPS_FOURTEENTH sub-steps per bus clock period
  // ---------------------------------------------------------------
  localparam int PHASE_W = 6;
  localparam logic [5:0] STEPS_QUARTER = 6'h04;
  localparam logic [5:0] SECOND_AT_QUARTER = 6'h01;
  localparam logic [5:0] FOURTH_AT_QUARTER = 6'h03;
  localparam logic [5:0] STEPS_TENTH = 6'h0A;
  localparam logic [5:0] SECOND_AT_TENTH = 6'h03;
  localparam logic [5:0] FOURTH_AT_TENTH = 6'h08;
  localparam logic [5:0] STEPS_FOURTEENTH = 6'h0E;
  localparam logic [5:0] SECOND_AT_FOURTEENTH = 6'h04;
  localparam logic [5:0] FOURTH_AT_FOURTEENTH = 6'h0B;
  localparam logic [5:0] PHASE_RESET = 6'h00;
  // one step before zero: the 6-bit increment wraps it onto a first tick
  localparam logic [5:0] PHASE_PRESTART = 6'h3F;

  // decoded clock factors for one mode code
  typedef struct packed {
    logic valid;
    logic [4:0] comm_x2;
    logic [4:0] core_x2;
    logic [4:0] pci_div;
  } cmt_cfg_t;

  // tick strobes, one-cycle pulses on the sub-step clock
  typedef struct packed {
    logic first_tick;
    logic second_tick;
    logic third_tick;
    logic fourth_tick;
  } cmt_ticks_t;

  // divider state
  typedef enum logic [1:0] {
    CMT_RESET = 2'b00,
    CMT_RUN = 2'b01,
    CMT_BAD = 2'b10
  } cmt_state_t;

  localparam cmt_cfg_t CFG_RESET = '{valid: 1'b0, comm_x2: 5'h00, core_x2: 5'h00, pci_div: 5'h00};
endpackage

// [rtl/cmt_clock_mode_tick_generator.sv]
// module: clock-mode decoder and four-tick generator for memory-controller output timing
`timescale 1ns/1ps
// Function
// - four tick points per bus clock period
// - first tick rising edge, third falling edge
// - second/fourth placement follows PLL ratio
// - other outputs launch on rising edge
// - memory outputs may change at any tick
// - mode code selects comm, core, pci factors
// - upper bits from word, lower from pins
// - comm clock equals bus times comm factor
// - core clock equals bus times core factor
module cmt_clock_mode_tick_generator (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hard_reset_i,
  input wire logic [31:0] reset_config_word_i,
  input wire logic [2:0] clock_mode_pins_i,
  input wire logic pci_clock_range_select_i,
  input wire logic [3:0] mem_out_tick_sel_i,
  input wire logic mem_out_d_i,
  input wire logic bus_out_d_i,
  output logic [6:0] mode_code_o,
  output logic mode_invalid_o,
  output logic [4:0] comm_mult_x2_o,
  output logic [4:0] core_mult_x2_o,
  output logic [4:0] pci_div_o,
  output logic bus_input_clock_o,
  output cmt_pkg::cmt_ticks_t ticks_o,
  output logic mem_out_q_o,
  output logic bus_out_q_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    cmt_pkg::cmt_state_t st;
    logic [6:0] mode;
    cmt_pkg::cmt_cfg_t cfg;
    logic [5:0] phase;
    logic bus_clk;
    cmt_pkg::cmt_ticks_t ticks;
    logic mem_q;
    logic bus_q;
  } cmt_state_all_t;

  cmt_state_all_t r;
  cmt_state_all_t next_r;
  cmt_pkg::cmt_cfg_t dec;
  logic [6:0] code_in;
  logic [5:0] steps;
  logic [5:0] second_pos;
  logic [5:0] fourth_pos;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // word bits and pins
  assign code_in = {reset_config_word_i[cmt_pkg::CFG_WORD_UPPER_MSB:cmt_pkg::CFG_WORD_UPPER_LSB],
                    clock_mode_pins_i};

  // table decode, comm and core factors held as twice their value, pci divider as is
  function automatic cmt_pkg::cmt_cfg_t decode(input logic [6:0] c);
    cmt_pkg::cmt_cfg_t d;
    d = '{valid: 1'b1, comm_x2: 5'h00, core_x2: 5'h00, pci_div: 5'h00};
    case (c)
      7'h00: d = '{1'b1, 5'h04, 5'h05, 5'h02};
      7'h01: d = '{1'b1, 5'h04, 5'h06, 5'h02};
      7'h02: d = '{1'b1, 5'h05, 5'h06, 5'h03};
      7'h03: d = '{1'b1, 5'h05, 5'h07, 5'h03};
      7'h04: d = '{1'b1, 5'h05, 5'h08, 5'h03};
      7'h05: d = '{1'b1, 5'h06, 5'h06, 5'h03};
      7'h06: d = '{1'b1, 5'h07, 5'h07, 5'h03};
      7'h07: d = '{1'b1, 5'h06, 5'h08, 5'h03};
      7'h08: d = '{1'b1, 5'h06, 5'h0A, 5'h03};
      7'h09: d = '{1'b1, 5'h06, 5'h0C, 5'h03};
      7'h0A: d = '{1'b1, 5'h06, 5'h0E, 5'h03};
      7'h0B: d = '{1'b1, 5'h06, 5'h10, 5'h03};
      7'h10: d = '{1'b1, 5'h08, 5'h0A, 5'h04};
      7'h11: d = '{1'b1, 5'h08, 5'h0C, 5'h04};
      7'h12: d = '{1'b1, 5'h08, 5'h0E, 5'h04};
      7'h13: d = '{1'b1, 5'h08, 5'h10, 5'h04};
      7'h14: d = '{1'b1, 5'h08, 5'h0A, 5'h06};
      7'h15: d = '{1'b1, 5'h08, 5'h0B, 5'h06};
      7'h16: d = '{1'b1, 5'h08, 5'h0C, 5'h06};
      7'h18: d = '{1'b1, 5'h0A, 5'h0A, 5'h05};
      7'h19: d = '{1'b1, 5'h0A, 5'h0C, 5'h05};
      7'h1A: d = '{1'b1, 5'h0A, 5'h0E, 5'h05};
      7'h1B: d = '{1'b1, 5'h0A, 5'h10, 5'h05};
      7'h21: d = '{1'b1, 5'h0C, 5'h0C, 5'h06};
      7'h22: d = '{1'b1, 5'h0C, 5'h0E, 5'h06};
      7'h23: d = '{1'b1, 5'h0C, 5'h10, 5'h06};
      7'h28: d = '{1'b1, 5'h04, 5'h05, 5'h02};
      7'h29: d = '{1'b1, 5'h04, 5'h06, 5'h02};
      7'h2A: d = '{1'b1, 5'h04, 5'h07, 5'h02};
      7'h2B: d = '{1'b1, 5'h04, 5'h08, 5'h02};
      7'h2C: d = '{1'b1, 5'h04, 5'h09, 5'h02};
      7'h2D: d = '{1'b1, 5'h06, 5'h07, 5'h05};
      7'h2E: d = '{1'b1, 5'h06, 5'h08, 5'h05};
      7'h2F: d = '{1'b1, 5'h06, 5'h09, 5'h05};
      7'h30: d = '{1'b1, 5'h05, 5'h05, 5'h03};
      7'h31: d = '{1'b1, 5'h05, 5'h06, 5'h03};
      7'h32: d = '{1'b1, 5'h05, 5'h07, 5'h03};
      7'h33: d = '{1'b1, 5'h05, 5'h08, 5'h03};
      7'h34: d = '{1'b1, 5'h05, 5'h09, 5'h03};
      7'h35: d = '{1'b1, 5'h05, 5'h0A, 5'h03};
      7'h36: d = '{1'b1, 5'h05, 5'h0C, 5'h03};
      7'h39: d = '{1'b1, 5'h06, 5'h06, 5'h03};
      7'h3A: d = '{1'b1, 5'h06, 5'h07, 5'h03};
      7'h3B: d = '{1'b1, 5'h06, 5'h08, 5'h03};
      7'h3C: d = '{1'b1, 5'h06, 5'h09, 5'h03};
      7'h41: d = '{1'b1, 5'h06, 5'h06, 5'h04};
      7'h5C: d = '{1'b1, 5'h05, 5'h08, 5'h04};
      7'h5D: d = '{1'b1, 5'h05, 5'h09, 5'h04};
      7'h68: d = '{1'b1, 5'h05, 5'h06, 5'h05};
      7'h69: d = '{1'b1, 5'h05, 5'h07, 5'h05};
      7'h6A: d = '{1'b1, 5'h05, 5'h08, 5'h05};
      7'h6B: d = '{1'b1, 5'h05, 5'h09, 5'h05};
      7'h6C: d = '{1'b1, 5'h05, 5'h0A, 5'h05};
      7'h6D: d = '{1'b1, 5'h04, 5'h06, 5'h05};
      7'h6E: d = '{1'b1, 5'h04, 5'h08, 5'h05};
      7'h70: d = '{1'b1, 5'h06, 5'h07, 5'h06};
      7'h71: d = '{1'b1, 5'h06, 5'h08, 5'h06};
      7'h72: d = '{1'b1, 5'h06, 5'h09, 5'h06};
      7'h73: d = '{1'b1, 5'h06, 5'h0A, 5'h06};
      7'h74: d = '{1'b1, 5'h06, 5'h0B, 5'h06};
      default: d = cmt_pkg::CFG_RESET;
    endcase
    return d;
  endfunction

  assign dec = decode(r.mode);

  // sub-step grid chosen from the core ratio
  always_comb begin
    steps = cmt_pkg::STEPS_QUARTER;
    second_pos = cmt_pkg::SECOND_AT_QUARTER;
    fourth_pos = cmt_pkg::FOURTH_AT_QUARTER;
    if (r.cfg.core_x2 == cmt_pkg::RATIO_HALF_2_5) begin
      steps = cmt_pkg::STEPS_TENTH;
      second_pos = cmt_pkg::SECOND_AT_TENTH;
      fourth_pos = cmt_pkg::FOURTH_AT_TENTH;
    end else if (r.cfg.core_x2 == cmt_pkg::RATIO_HALF_3_5) begin
      steps = cmt_pkg::STEPS_FOURTEENTH;
      second_pos = cmt_pkg::SECOND_AT_FOURTEENTH;
      fourth_pos = cmt_pkg::FOURTH_AT_FOURTEENTH;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ticks = '0;
    case (r.st)
      cmt_pkg::CMT_RESET: begin
        if (!hard_reset_i) begin
          next_r.cfg = decode(r.mode);
          // park before zero so the bus clock never rises without a first tick
          next_r.phase = cmt_pkg::PHASE_PRESTART;
          next_r.st = dec.valid ? cmt_pkg::CMT_RUN : cmt_pkg::CMT_BAD;
        end
      end
      cmt_pkg::CMT_RUN: begin
        // phase counter spans one bus period
        next_r.phase = (r.phase == steps - 6'h01) ? cmt_pkg::PHASE_RESET : r.phase + 6'h01;
        // first tick rising, third tick falling
        next_r.ticks.first_tick = (next_r.phase == cmt_pkg::PHASE_RESET);
        next_r.ticks.third_tick = (next_r.phase == (steps >> 1));
        // second and fourth from the grid
        next_r.ticks.second_tick = (next_r.phase == second_pos);
        next_r.ticks.fourth_tick = (next_r.phase == fourth_pos);
        next_r.bus_clk = (next_r.phase < (steps >> 1));
        // bus outputs launch on the rising edge only
        if (next_r.ticks.first_tick) begin
          next_r.bus_q = bus_out_d_i;
        end
        // memory outputs change at any selected tick
        if (|(mem_out_tick_sel_i & next_r.ticks)) begin
          next_r.mem_q = mem_out_d_i;
        end
      end
      cmt_pkg::CMT_BAD: begin
        next_r.bus_clk = 1'b0;
      end
      default: begin
        next_r.st = cmt_pkg::CMT_RESET;
      end
    endcase
    // capture while hard reset stands, held after
    if (hard_reset_i) begin
      next_r.st = cmt_pkg::CMT_RESET;
      next_r.mode = code_in;
      next_r.cfg = cmt_pkg::CFG_RESET;
      next_r.ticks = '0;
      next_r.bus_clk = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs from state
  assign mode_code_o = r.mode;
  assign mode_invalid_o = (r.st == cmt_pkg::CMT_BAD);
  assign comm_mult_x2_o = r.cfg.comm_x2;
  assign core_mult_x2_o = r.cfg.core_x2;
  assign pci_div_o = r.cfg.pci_div;
  assign bus_input_clock_o = r.bus_clk;
  assign ticks_o = r.ticks;
  assign mem_out_q_o = r.mem_q;
  assign bus_out_q_o = r.bus_q;
endmodule

// [verification/cmt_tick_chk.sv]
// checker: tick order, tick alignment, mode capture and launch timing
`timescale 1ns/1ps
module cmt_tick_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hard_reset_i,
  input wire logic [31:0] reset_config_word_i,
  input wire logic [2:0] clock_mode_pins_i,
  input wire logic [3:0] mem_out_tick_sel_i,
  input wire logic mem_out_d_i,
  input wire logic bus_out_d_i,
  input wire logic [6:0] mode_code_o,
  input wire logic mode_invalid_o,
  input wire logic [4:0] comm_mult_x2_o,
  input wire logic [4:0] core_mult_x2_o,
  input wire logic [4:0] pci_div_o,
  input wire logic bus_input_clock_o,
  input wire cmt_pkg::cmt_ticks_t ticks_o,
  input wire logic mem_out_q_o,
  input wire logic bus_out_q_o
);
  wire logic tk_first = ticks_o.first_tick;
  wire logic tk_second = ticks_o.second_tick;
  wire logic tk_third = ticks_o.third_tick;
  wire logic tk_fourth = ticks_o.fourth_tick;
  wire logic [14:0] factors = {comm_mult_x2_o, core_mult_x2_o, pci_div_o};
  // hard reset aborts a period, so it disables the tick checks too
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || hard_reset_i);
  // one bus clock period on each tick grid, first tick to first tick
  sequence s_qtr; ##1 tk_second ##1 tk_third ##1 tk_fourth ##1 tk_first; endsequence
  sequence s_ten; ##3 tk_second ##2 tk_third ##3 tk_fourth ##2 tk_first; endsequence
  sequence s_ftn; ##4 tk_second ##3 tk_third ##4 tk_fourth ##3 tk_first; endsequence
  property p_qtr; tk_first && !core_mult_x2_o[0] |-> s_qtr; endproperty
  property p_ten; tk_first && core_mult_x2_o == 5'h05 |-> s_ten; endproperty
  property p_ftn; tk_first && core_mult_x2_o == 5'h07 |-> s_ftn; endproperty
  property p_rise; tk_first |-> $rose(bus_input_clock_o); endproperty
  property p_rise_only; $rose(bus_input_clock_o) |-> tk_first; endproperty
  property p_fall; tk_third |-> $fell(bus_input_clock_o); endproperty
  property p_invalid; mode_invalid_o |-> ticks_o == 4'h0 && factors == 15'h0000; endproperty
  property p_capture;
    disable iff (rst_i) hard_reset_i |=> mode_code_o == $past({reset_config_word_i[31:28], clock_mode_pins_i});
  endproperty
  property p_hold;
    disable iff (rst_i) !hard_reset_i && !$past(hard_reset_i) && !$past(hard_reset_i, 2)
      |-> $stable({mode_code_o, mode_invalid_o, factors});
  endproperty
  property p_bus; bus_out_q_o == (tk_first ? $past(bus_out_d_i) : $past(bus_out_q_o)); endproperty
  property p_mem;
    mem_out_q_o == ((|(4'(ticks_o) & $past(mem_out_tick_sel_i))) ? $past(mem_out_d_i) : $past(mem_out_q_o));
  endproperty
  a_qtr: assert property (p_qtr) else $error("quarter grid tick order broken");
  a_ten: assert property (p_ten) else $error("tenth grid tick order broken");
  a_ftn: assert property (p_ftn) else $error("fourteenth grid tick order broken");
  a_rise: assert property (p_rise) else $error("first tick off the rising bus clock");
  a_rise_only: assert property (p_rise_only) else $error("bus clock rose without a first tick");
  a_fall: assert property (p_fall) else $error("third tick off the falling bus clock");
  a_invalid: assert property (p_invalid) else $error("reserved code still ticks");
  a_capture: assert property (p_capture) else $error("mode code not captured");
  a_hold: assert property (p_hold) else $error("mode changed after hard reset");
  a_bus: assert property (p_bus) else $error("bus output launched off first tick");
  a_mem: assert property (p_mem) else $error("memory output missed its tick");
endmodule
bind cmt_clock_mode_tick_generator cmt_tick_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .hard_reset_i(hard_reset_i),
  .reset_config_word_i(reset_config_word_i), .clock_mode_pins_i(clock_mode_pins_i),
  .mem_out_tick_sel_i(mem_out_tick_sel_i), .mem_out_d_i(mem_out_d_i), .bus_out_d_i(bus_out_d_i),
  .mode_code_o(mode_code_o), .mode_invalid_o(mode_invalid_o), .comm_mult_x2_o(comm_mult_x2_o),
  .core_mult_x2_o(core_mult_x2_o), .pci_div_o(pci_div_o), .bus_input_clock_o(bus_input_clock_o),
  .ticks_o(ticks_o), .mem_out_q_o(mem_out_q_o), .bus_out_q_o(bus_out_q_o));

// [verification/cmt_cfg_source.sv]
// partner: reset configuration source driving the mode word and the mode pins
`timescale 1ns/1ps
module cmt_cfg_source (
  input wire logic clk_i,
  input wire logic hard_reset_i,
  input wire logic [6:0] code_i,
  output logic [31:0] word_o,
  output logic [2:0] pins_o
);
  // models a single-master pipelined system
  // with internal arbiter and memory controller, heavy-load enables set
  initial word_o = 32'h00000000;
  initial pins_o = 3'h0;
  // upper bits, pins
  // code shown only in hard reset; once released the lines flip every cycle
  always @(posedge clk_i) begin
    if (hard_reset_i) begin
      word_o <= {code_i[6:3], 28'h5A5A5A5};
      pins_o <= code_i[2:0];
    end else begin
      word_o <= ~word_o;
      pins_o <= ~pins_o;
    end
  end
endmodule

// [verification/testbench.sv]
// testbench: mode decode, tick period and launch checks for the tick generator
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hard_reset_i = 1'b0;
  logic [6:0] code = 7'h00;
  logic [3:0] mask = 4'hF;
  logic bus_d = 1'b0;
  logic mem_d = 1'b0;
  logic bus_seen = 1'b0;
  logic mem_seen = 1'b0;
  logic [31:0] seed = 32'hB99C;
  logic [31:0] r = 32'hB99C;
  logic [31:0] word;
  logic [2:0] pins;
  logic [6:0] mode;
  logic inv, bclk, mem_q, bus_q;
  logic [4:0] comm, core, pci;
  cmt_pkg::cmt_ticks_t ticks;
  int miscompares = 0;
  int tests_run = 0;
  // code, valid, twice comm factor, twice core factor, pci divider
  // listed codes keep clocks above their floors
  logic [22:0] tbl [9] = '{{7'h00, 1'b1, 5'h04, 5'h05, 5'h02}, {7'h1B, 1'b1, 5'h0A, 5'h10, 5'h05},
    {7'h06, 1'b1, 5'h07, 5'h07, 5'h03}, {7'h15, 1'b1, 5'h08, 5'h0B, 5'h06}, {7'h6D, 1'b1, 5'h04, 5'h06, 5'h05},
    {7'h30, 1'b1, 5'h05, 5'h05, 5'h03}, {7'h20, 1'b0, 15'h0000}, {7'h38, 1'b0, 15'h0000}, {7'h60, 1'b0, 15'h0000}};
  always #2 clk_i = ~clk_i;
  cmt_cfg_source src (.clk_i(clk_i), .hard_reset_i(hard_reset_i), .code_i(code), .word_o(word), .pins_o(pins));
  cmt_clock_mode_tick_generator dut (.clk_i(clk_i), .rst_i(rst_i), .hard_reset_i(hard_reset_i),
    .reset_config_word_i(word), .clock_mode_pins_i(pins), .pci_clock_range_select_i(1'b0),
    .mem_out_tick_sel_i(mask), .mem_out_d_i(mem_d), .bus_out_d_i(bus_d), .mode_code_o(mode),
    .mode_invalid_o(inv), .comm_mult_x2_o(comm), .core_mult_x2_o(core), .pci_div_o(pci),
    .bus_input_clock_o(bclk), .ticks_o(ticks), .mem_out_q_o(mem_q), .bus_out_q_o(bus_q));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04000007 : 32'h00000000);
  endfunction
  // bus clock period in system cycles from twice the core factor, 0 for odd values other than 5 and 7
  function automatic int period_of(input logic [4:0] c);
    return (c == 5'h05) ? 10 : (c == 5'h07) ? 14 : c[0] ? 0 : 4;
  endfunction
  // strobes {first, second, third, fourth} expected at a phase of a period of p cycles
  function automatic logic [3:0] ticks_at(input int ph, input int p);
    int sec_at;
    int four_at;
    sec_at = (p == 10) ? 3 : (p == 14) ? 4 : 1;
    four_at = (p == 10) ? 8 : (p == 14) ? 11 : 3;
    return {ph == 0, ph == sec_at, ph == p / 2, ph == four_at};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // random launch data every cycle, and the values the design took at that edge
  always @(posedge clk_i) begin
    seed <= lfsr(seed);
    bus_d <= seed[0];
    mem_d <= seed[7];
    bus_seen <= bus_d;
    mem_seen <= mem_d;
  end
  // one hard reset with a table entry, then decode and period checks
  task automatic run(input int idx);
    logic [22:0] e;
    int n;
    int p;
    e = tbl[idx];
    p = e[15] ? period_of(e[9:5]) : 0;
    r = lfsr(r);
    @(posedge clk_i);
    hard_reset_i <= 1'b1;
    code <= e[22:16];
    mask <= r[3:0];
    repeat (4) @(posedge clk_i);
    hard_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check(mode, e[22:16]);
    check(inv, !e[15]);
    check({comm, core, pci}, e[14:0]);
    n = 0;
    while (ticks.first_tick !== 1'b1 && n < 30) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    n = 0;
    // one period from a first tick: strobes, bus clock and launches each cycle
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (p != 0) begin
        check(ticks, ticks_at(n % p, p));
        check(bclk, (n % p) < p / 2);
      end
      if (!e[15]) check(ticks, 4'h0);
      if (ticks.first_tick) check(bus_q, bus_seen);
      if (|(mask & ticks)) check(mem_q, mem_seen);
    end while (ticks.first_tick !== 1'b1 && n < 30);
    if (p != 0) check(n, p);
  endtask
  // reset, every table entry, then random picks
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) run(i);
    for (int i = 0; i < 6; i++) run(int'(lfsr(r) % 9));
    close_out;
  end
  // watchdog against a hang
  initial begin
    #20000;
    miscompares++;
    close_out;
  end
endmodule
